// File: system_tick_timers.sv
// System timebase: micro, milli and tenth ticks, two interval timers and watchdog
`timescale 1ns/1ps
module system_tick_timers
   import tick_timer_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Special function register bus
   input wire sfr_req_s sfrReq,
   output logic [7:0] sfrRdData,
   output logic sfrHit,
   // Power-down controls
   input wire logic tickPowerDown,
   input wire logic guardPowerDown,
   // Time bases for the flash timing logic
   output logic microTick,
   output logic milliTick,
   output logic tenthTick,
   // Interrupt status
   output logic longIrqPending,
   output logic shortIrqPending,
   // Watchdog
   output logic guardRunning,
   output logic guardExpire
);

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   logic wrLong;
   logic wrShort;
   logic wrMicro;
   logic wrMilliLow;
   logic wrMilliHigh;
   logic wrTenth;
   logic wrGuard;
   logic rdLong;
   logic rdShort;

   assign wrLong = sfrReq.wr && (sfrReq.addr == LONG_INTERVAL_ADDR);
   assign wrShort = sfrReq.wr && (sfrReq.addr == SHORT_INTERVAL_ADDR);
   assign wrMicro = sfrReq.wr && (sfrReq.addr == MICRO_DIV_ADDR);
   assign wrMilliLow = sfrReq.wr && (sfrReq.addr == MILLI_LOW_ADDR);
   assign wrMilliHigh = sfrReq.wr && (sfrReq.addr == MILLI_HIGH_ADDR);
   assign wrTenth = sfrReq.wr && (sfrReq.addr == TENTH_DIV_ADDR);
   assign wrGuard = sfrReq.wr && (sfrReq.addr == GUARD_CTRL_ADDR);
   assign rdLong = sfrReq.rd && (sfrReq.addr == LONG_INTERVAL_ADDR);
   assign rdShort = sfrReq.rd && (sfrReq.addr == SHORT_INTERVAL_ADDR);

   // ----------------------------------------------------------------
   // Divider registers
   // ----------------------------------------------------------------
   logic [MICRO_W-1:0] microDiv_reg;
   logic [7:0] milliLow_reg;
   logic [7:0] milliHigh_reg;
   logic [7:0] tenthDiv_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         microDiv_reg <= MICRO_DIV_RESET;
      end else if (wrMicro) begin
         microDiv_reg <= sfrReq.wdata[MICRO_W-1:0];
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         milliLow_reg <= MILLI_LOW_RESET;
      end else if (wrMilliLow) begin
         milliLow_reg <= sfrReq.wdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         milliHigh_reg <= MILLI_HIGH_RESET;
      end else if (wrMilliHigh) begin
         milliHigh_reg <= sfrReq.wdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tenthDiv_reg <= TENTH_DIV_RESET;
      end else if (wrTenth) begin
         tenthDiv_reg <= sfrReq.wdata;
      end
   end

   // ----------------------------------------------------------------
   // Tick chain
   // ----------------------------------------------------------------
   // Powering down holds every divider cleared, so ticks restart in phase
   tick_divider #(.W(MICRO_W)) microDivider (
      .mclk(mclk),
      .resetn(resetn),
      .hold(tickPowerDown),
      .stepEn(1'b1),
      .div(microDiv_reg),
      .tick(microTick)
   );

   tick_divider #(.W(MILLI_W)) milliDivider (
      .mclk(mclk),
      .resetn(resetn),
      .hold(tickPowerDown),
      .stepEn(1'b1),
      .div({milliHigh_reg, milliLow_reg}),
      .tick(milliTick)
   );

   tick_divider #(.W(TENTH_W)) tenthDivider (
      .mclk(mclk),
      .resetn(resetn),
      .hold(tickPowerDown),
      .stepEn(milliTick),
      .div(tenthDiv_reg),
      .tick(tenthTick)
   );

   // ----------------------------------------------------------------
   // Interval timers
   // ----------------------------------------------------------------
   logic [7:0] longValue;
   logic [7:0] shortValue;

   interval_timer longTimer (
      .mclk(mclk),
      .resetn(resetn),
      .hold(tickPowerDown),
      .tickEn(tenthTick),
      .wrEn(wrLong),
      .wrData(sfrReq.wdata),
      .rdEn(rdLong),
      .readValue(longValue),
      .irqPending(longIrqPending)
   );

   // The flag in ext_irq_ctrl lives outside; software clears it separately
   interval_timer shortTimer (
      .mclk(mclk),
      .resetn(resetn),
      .hold(tickPowerDown),
      .tickEn(milliTick),
      .wrEn(wrShort),
      .wrData(sfrReq.wdata),
      .rdEn(rdShort),
      .readValue(shortValue),
      .irqPending(shortIrqPending)
   );

   // ----------------------------------------------------------------
   // Watchdog control register and sequence detect
   // ----------------------------------------------------------------
   logic [7:0] guardCtrl_reg;
   logic [GUARD_SEQ_N-1:0] seqPulse;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         guardCtrl_reg <= GUARD_CTRL_RESET;
      end else if (wrGuard) begin
         guardCtrl_reg <= sfrReq.wdata;
      end
   end

   // A control bit stored as 1 and then written 0 marks a completed sequence
   genvar g;
   generate
      for (g = 0; g < GUARD_SEQ_N; g++) begin : seqDetect
         assign seqPulse[g] = wrGuard && guardCtrl_reg[GUARD_SEQ_LSB + g]
            && !sfrReq.wdata[GUARD_SEQ_LSB + g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Watchdog counter
   // ----------------------------------------------------------------
   guard_state_e guardState_reg;
   logic [GUARD_RUN_W-1:0] guardCnt_reg;
   logic [GUARD_RUN_W-1:0] guardLimit;
   logic guardFire;

   assign guardLimit = {1'b0, guardCtrl_reg[GUARD_CNT_W-1:0]} + 1'b1;
   // A kick in the firing cycle wins, so a timely restart never lets an expiry through
   assign guardFire = (guardState_reg == GUARD_RUN) && !guardPowerDown && tenthTick
      && (guardCnt_reg == guardLimit) && !seqPulse[SEQ_KICK];
   assign guardRunning = (guardState_reg == GUARD_RUN);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         guardState_reg <= GUARD_IDLE;
      end else begin
         case (guardState_reg)
            GUARD_IDLE: begin
               if (seqPulse[SEQ_ARM]) begin
                  guardState_reg <= GUARD_RUN;
               end
            end
            GUARD_RUN: begin
               if (seqPulse[SEQ_DISARM]) begin
                  guardState_reg <= GUARD_IDLE;
               end
            end
            default: begin
               guardState_reg <= GUARD_IDLE;
            end
         endcase
      end
   end

   // Counting whole tenth ticks from an unaligned start gives the one-count uncertainty
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         guardCnt_reg <= '0;
      end else if (guardState_reg != GUARD_RUN || guardPowerDown || seqPulse[SEQ_KICK] || seqPulse[SEQ_DISARM]) begin
         guardCnt_reg <= '0;
      end else if (guardFire) begin
         guardCnt_reg <= '0;
      end else if (tenthTick) begin
         guardCnt_reg <= guardCnt_reg + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         guardExpire <= 1'b0;
      end else begin
         guardExpire <= guardFire;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [7:0] rdMux;
   logic rdHit;

   always_comb begin
      rdHit = 1'b1;
      case (sfrReq.addr)
         LONG_INTERVAL_ADDR: rdMux = longValue;
         SHORT_INTERVAL_ADDR: rdMux = shortValue;
         MICRO_DIV_ADDR: rdMux = {3'h0, microDiv_reg};
         MILLI_LOW_ADDR: rdMux = milliLow_reg;
         MILLI_HIGH_ADDR: rdMux = milliHigh_reg;
         TENTH_DIV_ADDR: rdMux = tenthDiv_reg;
         GUARD_CTRL_ADDR: rdMux = guardCtrl_reg;
         default: begin
            rdMux = 8'h00;
            rdHit = 1'b0;
         end
      endcase
   end

   // Registered read data; unmapped addresses return zero and no hit
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sfrRdData <= 8'h00;
         sfrHit <= 1'b0;
      end else if (sfrReq.rd) begin
         sfrRdData <= rdMux;
         sfrHit <= rdHit;
      end else begin
         sfrHit <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence armSeq;
      wrGuard && sfrReq.wdata[GUARD_ARM_BIT] ##[1:1000] seqPulse[SEQ_ARM];
   endsequence

   a_arm_sets_run: assert property (@(posedge mclk) disable iff (!resetn)
      armSeq |=> guardRunning)
      else $error("arm sequence did not start the watchdog");

   a_disarm_stops: assert property (@(posedge mclk) disable iff (!resetn)
      seqPulse[SEQ_DISARM] && guardRunning |=> !guardRunning && guardCnt_reg == '0)
      else $error("disarm sequence did not stop the watchdog");

   a_kick_restarts: assert property (@(posedge mclk) disable iff (!resetn)
      seqPulse[SEQ_KICK] |=> guardCnt_reg == '0 && !guardExpire)
      else $error("kick did not restart the watchdog counter");

   a_single_write_idle: assert property (@(posedge mclk) disable iff (!resetn)
      wrGuard && !guardCtrl_reg[GUARD_ARM_BIT] && !guardRunning |=> !guardRunning)
      else $error("single write started the watchdog");

   a_expire_pulse: assert property (@(posedge mclk) disable iff (!resetn)
      guardExpire |=> !guardExpire)
      else $error("expiry pulse longer than one cycle");

   a_expire_count: assert property (@(posedge mclk) disable iff (!resetn)
      guardFire |-> guardCnt_reg == guardCtrl_reg[GUARD_CNT_W-1:0] + 6'h01 && tenthTick)
      else $error("watchdog fired at the wrong count");

   a_tick_powerdown: assert property (@(posedge mclk) disable iff (!resetn)
      tickPowerDown ##1 tickPowerDown |-> !microTick && !milliTick && !tenthTick)
      else $error("ticks ran while powered down");

   a_guard_powerdown: assert property (@(posedge mclk) disable iff (!resetn)
      guardPowerDown |=> guardCnt_reg == '0 && !guardExpire)
      else $error("watchdog counted while powered down");

   a_tenth_from_milli: assert property (@(posedge mclk) disable iff (!resetn)
      tenthTick |-> $past(milliTick))
      else $error("tenth tick without a millisecond tick");

   a_micro_write: assert property (@(posedge mclk) disable iff (!resetn)
      wrMicro |=> microDiv_reg == $past(sfrReq.wdata[MICRO_W-1:0]))
      else $error("micro divider write did not land");

   a_milli_low_write: assert property (@(posedge mclk) disable iff (!resetn)
      wrMilliLow |=> milliLow_reg == $past(sfrReq.wdata))
      else $error("milli divider low write did not land");

   a_milli_high_write: assert property (@(posedge mclk) disable iff (!resetn)
      wrMilliHigh |=> milliHigh_reg == $past(sfrReq.wdata))
      else $error("milli divider high write did not land");

   a_tenth_write: assert property (@(posedge mclk) disable iff (!resetn)
      wrTenth |=> tenthDiv_reg == $past(sfrReq.wdata))
      else $error("tenth divider write did not land");

   a_guard_write: assert property (@(posedge mclk) disable iff (!resetn)
      wrGuard |=> guardCtrl_reg == $past(sfrReq.wdata))
      else $error("watchdog control write did not land");

   a_idle_cleared: assert property (@(posedge mclk) disable iff (!resetn)
      !guardRunning |-> guardCnt_reg == '0)
      else $error("stopped watchdog holds a nonzero count");

   a_arm_needs_seq: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(guardRunning) |-> $past(seqPulse[SEQ_ARM]))
      else $error("watchdog started without an arm sequence");

   a_stop_needs_seq: assert property (@(posedge mclk) disable iff (!resetn)
      $fell(guardRunning) |-> $past(seqPulse[SEQ_DISARM]))
      else $error("watchdog stopped without a disarm sequence");

   a_expire_running: assert property (@(posedge mclk) disable iff (!resetn)
      guardExpire |-> $past(guardRunning))
      else $error("expiry pulse while the watchdog was stopped");

   a_expire_on_tick: assert property (@(posedge mclk) disable iff (!resetn)
      guardExpire |-> $past(tenthTick))
      else $error("expiry pulse without a tenth tick");

endmodule

// File: tick_timer_pkg.sv
// Shared constants and types for the system tick timers and watchdog
//
// Overview of operation
// - Millisecond tick period is (milli_divider_high*256 + milli_divider_low + 1) clocks.
// - Hundred-millisecond tick divides the millisecond tick by tenth_divider plus one.
// - Microsecond tick divides the clock by five-bit micro_tick_divider field plus one.
// - Long-interval timer counts tenth ticks; period is (1 + long_count) tenth periods.
// - A read of long_interval_reg clears the pending long-interval interrupt unless it expires in the same cycle.
// - Long-interval interrupt state is driven out for the aux_irq_status register.
// - Long write with load_mode 0 holds the value until current count expires.
// - Long write with load_mode 1 loads the counter right after the write.
// - The load_mode bit of both interval registers always reads back as zero.
// - Short-interval timer counts millisecond ticks; period is (1 + count) milli periods.
// - A read of short_interval_reg clears the pending short-interval interrupt unless it expires in the same cycle.
// - Short-interval timer uses the same deferred or immediate load_mode behaviour.
// - The microsecond tick is exported to the flash timing logic.
// - The millisecond tick is exported to the flash timing logic.
// - Writing guard_arm 1 then 0 sets the watchdog enable-counting bit.
// - Writing guard_disarm 1 then 0 clears enable-counting and stops the watchdog.
// - Writing guard_kick 1 then 0 restarts the watchdog counter.
// - Unkicked enabled watchdog expires after timeout+1 to timeout+2 tenth periods.
// - tick_power_down stops the system timer logic; cleared lets it run.
// - guard_power_down stops the watchdog; cleared lets it run.
package tick_timer_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] LONG_INTERVAL_ADDR = 8'hf9;
   localparam logic [7:0] SHORT_INTERVAL_ADDR = 8'hfa;
   localparam logic [7:0] MICRO_DIV_ADDR = 8'hfb;
   localparam logic [7:0] MILLI_LOW_ADDR = 8'hfc;
   localparam logic [7:0] MILLI_HIGH_ADDR = 8'hfd;
   localparam logic [7:0] TENTH_DIV_ADDR = 8'hfe;
   localparam logic [7:0] GUARD_CTRL_ADDR = 8'hff;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [6:0] INTERVAL_RESET = 7'h7f;
   localparam logic [4:0] MICRO_DIV_RESET = 5'h03;
   localparam logic [7:0] MILLI_LOW_RESET = 8'h9f;
   localparam logic [7:0] MILLI_HIGH_RESET = 8'h0f;
   localparam logic [7:0] TENTH_DIV_RESET = 8'h63;
   localparam logic [7:0] GUARD_CTRL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int LOAD_MODE_BIT = 7;
   localparam int INTERVAL_W = 7;
   localparam int MICRO_W = 5;
   localparam int MILLI_W = 16;
   localparam int TENTH_W = 8;
   localparam int GUARD_ARM_BIT = 7;
   localparam int GUARD_DISARM_BIT = 6;
   localparam int GUARD_KICK_BIT = 5;
   localparam int GUARD_SEQ_LSB = 5;
   localparam int GUARD_SEQ_N = 3;
   localparam int GUARD_CNT_W = 5;
   localparam int GUARD_RUN_W = 6;
   localparam int SEQ_ARM = 2;
   localparam int SEQ_DISARM = 1;
   localparam int SEQ_KICK = 0;

   // Special function register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sfr_req_s;

   typedef enum logic {GUARD_IDLE, GUARD_RUN} guard_state_e;

endpackage

// File: tick_divider.sv
// Reloading down-counter that emits one enable pulse every div+1 input enables
`timescale 1ns/1ps
module tick_divider
   import tick_timer_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Control
   input wire logic hold,
   input wire logic stepEn,
   input wire logic [W-1:0] div,
   // Output
   output logic tick
);

   logic [W-1:0] cnt_reg;

   // Counting down lets a new divisor take effect at the next wrap without glitches
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (hold) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else if (stepEn) begin
         if (cnt_reg == '0) begin
            cnt_reg <= div;
            tick <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg - 1'b1;
            tick <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end

   a_tick_spacing: assert property (@(posedge mclk) disable iff (!resetn)
      tick |-> !$past(tick) || ($past(div) == '0))
      else $error("divider ticks back to back with nonzero divisor");

endmodule

// File: interval_timer.sv
// Reloadable interval timer with deferred or immediate load and read-clear flag
`timescale 1ns/1ps
module interval_timer
   import tick_timer_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Time base
   input wire logic hold,
   input wire logic tickEn,
   // Register access
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic rdEn,
   output logic [7:0] readValue,
   // Interrupt
   output logic irqPending
);

   logic [INTERVAL_W-1:0] held_reg;
   logic [INTERVAL_W-1:0] cnt_reg;
   logic expire;

   assign expire = tickEn && !hold && (cnt_reg == '0);
   assign readValue = {1'b0, held_reg};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         held_reg <= INTERVAL_RESET;
      end else if (wrEn) begin
         held_reg <= wrData[INTERVAL_W-1:0];
      end
   end

   // Immediate load beats the tick; deferred values wait in held_reg for the wrap
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= INTERVAL_RESET;
      end else if (wrEn && wrData[LOAD_MODE_BIT]) begin
         cnt_reg <= wrData[INTERVAL_W-1:0];
      end else if (hold) begin
         cnt_reg <= cnt_reg;
      end else if (expire) begin
         cnt_reg <= held_reg;
      end else if (tickEn) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // Set wins over the read clear so no expiry is lost
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irqPending <= 1'b0;
      end else if (expire) begin
         irqPending <= 1'b1;
      end else if (rdEn) begin
         irqPending <= 1'b0;
      end
   end

   a_irq_on_expire: assert property (@(posedge mclk) disable iff (!resetn)
      expire |=> irqPending)
      else $error("interval expiry did not raise the flag");

   a_read_clears: assert property (@(posedge mclk) disable iff (!resetn)
      rdEn && !expire |=> !irqPending)
      else $error("read did not clear pending flag");

   a_immediate_load: assert property (@(posedge mclk) disable iff (!resetn)
      wrEn && wrData[LOAD_MODE_BIT] |=> cnt_reg == $past(wrData[INTERVAL_W-1:0]))
      else $error("immediate load did not reach the counter");

   a_deferred_load: assert property (@(posedge mclk) disable iff (!resetn)
      wrEn && !wrData[LOAD_MODE_BIT] && !expire && !tickEn |=> cnt_reg == $past(cnt_reg))
      else $error("deferred write disturbed the running count");

   a_load_mode_zero: assert property (@(posedge mclk) disable iff (!resetn)
      readValue[LOAD_MODE_BIT] == 1'b0)
      else $error("load mode bit reads as one");

endmodule

// File: sfr_core_model.sv
// Processor core model that drives the special function register bus
`timescale 1ns/1ps
module sfr_core_model
   import tick_timer_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Register bus
   output sfr_req_s sfrReq,
   input wire logic [7:0] sfrRdData,
   input wire logic sfrHit
);
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   // The aux flag that software also clears after short service lives outside this block
   initial begin
      sfrReq = '0;
   end

   // One strobe per request, held for exactly one sampling edge
   task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfrReq = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge mclk);
      sfrReq.wr = 1'b0;
   endtask

   task automatic sfrRead(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(negedge mclk);
      sfrReq = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge mclk);
      d = sfrRdData;
      h = sfrHit;
      sfrReq.rd = 1'b0;
   endtask
endmodule

// File: system_tick_timers_tb.sv
// Self-checking testbench for the system tick timers and watchdog
`timescale 1ns/1ps
module system_tick_timers_tb;
   import tick_timer_pkg::*;
   logic mclk;
   logic resetn;
   sfr_req_s sfrReq;
   logic [7:0] sfrRdData;
   logic sfrHit, tickPowerDown, guardPowerDown, microTick, milliTick, tenthTick;
   logic longIrqPending, shortIrqPending, guardRunning, guardExpire;
   int bad_count = 0;
   int comparisons = 0;
   int expCount = 0;
   int milliCount = 0;
   logic [7:0] rv;
   logic hv;

   // ----------------------------------------------------------------
   // Clock, monitors and instances
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (guardExpire === 1'b1) expCount++;
      if (milliTick === 1'b1) milliCount++;
   end

   system_tick_timers DUT (.mclk(mclk), .resetn(resetn), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
      .sfrHit(sfrHit), .tickPowerDown(tickPowerDown), .guardPowerDown(guardPowerDown),
      .microTick(microTick), .milliTick(milliTick), .tenthTick(tenthTick),
      .longIrqPending(longIrqPending), .shortIrqPending(shortIrqPending),
      .guardRunning(guardRunning), .guardExpire(guardExpire));

   sfr_core_model core (.mclk(mclk), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .sfrHit(sfrHit));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a);
      core.sfrRead(a, rv, hv);
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return microTick;
         1: return milliTick;
         2: return tenthTick;
         3: return shortIrqPending;
         default: return longIrqPending;
      endcase
   endfunction

   // Skips to a pulse, then counts clocks to the next one
   task automatic gap(input int sel, output int g);
      g = 0;
      while (pick(sel) !== 1'b1 && g < 5000) begin
         @(negedge mclk);
         g++;
      end
      g = 0;
      do begin
         @(negedge mclk);
         g++;
      end while (pick(sel) !== 1'b1 && g < 5000);
   endtask

   // Called where a pending flag was seen: clears it by a read and times the next one
   task automatic nextIrq(input int sel, input logic [7:0] a, output int g);
      rd(a);
      chk(pick(sel), 0);
      chk(rv[7], 0);
      g = 2;
      while (pick(sel) !== 1'b1 && g < 3000) begin
         @(negedge mclk);
         g++;
      end
   endtask

   task automatic interval(input int sel, input logic [7:0] a, input int c1, input int c2, input int unit);
      int g;
      core.sfrWrite(a, 8'h80 | 8'(c1));
      rd(a);
      chk(rv, 8'(c1));
      g = 0;
      while (pick(sel) !== 1'b1 && g < 3000) begin
         @(negedge mclk);
         g++;
      end
      chk(g <= (c1 + 1) * unit + 2, 1);
      nextIrq(sel, a, g);
      chk(g, (c1 + 1) * unit);
      core.sfrWrite(a, 8'(c2));
      nextIrq(sel, a, g);
      chk(g, (c1 + 1) * unit - 2);
      nextIrq(sel, a, g);
      chk(g, (c2 + 1) * unit);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] exp [7] = '{8'h7f, 8'h7f, 8'h03, 8'h9f, 8'h0f, 8'h63, 8'h00};
      for (int i = 0; i < 7; i++) begin
         rd(LONG_INTERVAL_ADDR + 8'(i));
         chk(rv, exp[i]);
         chk(hv, 1);
      end
      rd(8'hf8);
      chk({hv, rv}, 9'h000);
   endtask

   task automatic t_ticks();
      int g;
      core.sfrWrite(MICRO_DIV_ADDR, 8'he2);
      rd(MICRO_DIV_ADDR);
      chk(rv, 8'h02);
      gap(0, g);
      chk(g, 3);
      core.sfrWrite(MILLI_HIGH_ADDR, 8'h01);
      core.sfrWrite(MILLI_LOW_ADDR, 8'h02);
      gap(1, g);
      chk(g, 259);
      core.sfrWrite(MILLI_HIGH_ADDR, 8'h00);
      core.sfrWrite(MILLI_LOW_ADDR, 8'h03);
      core.sfrWrite(TENTH_DIV_ADDR, 8'h01);
      gap(1, g);
      chk(g, 4);
      gap(2, g);
      chk(g, 8);
      tickPowerDown = 1'b1;
      repeat (2) @(negedge mclk);
      g = milliCount;
      repeat (20) @(negedge mclk);
      chk(milliCount, g);
      tickPowerDown = 1'b0;
   endtask

   task automatic t_short();
      interval(3, SHORT_INTERVAL_ADDR, 2, 4, 4);
   endtask

   task automatic t_long();
      interval(4, LONG_INTERVAL_ADDR, 1, 0, 8);
   endtask

   task automatic t_guard();
      int e;
      int g;
      core.sfrWrite(GUARD_CTRL_ADDR, 8'h82);
      @(negedge mclk);
      chk(guardRunning, 0);
      core.sfrWrite(GUARD_CTRL_ADDR, 8'h02);
      g = 0;
      while (guardExpire !== 1'b1 && g < 200) begin
         @(negedge mclk);
         g++;
      end
      chk(g >= 23 && g <= 34, 1);
      @(negedge mclk);
      chk({guardExpire, guardRunning}, 2'b01);
      rd(GUARD_CTRL_ADDR);
      chk(rv, 8'h02);
      e = expCount;
      repeat (8) begin
         core.sfrWrite(GUARD_CTRL_ADDR, 8'ha2);
         core.sfrWrite(GUARD_CTRL_ADDR, 8'h02);
         repeat (8) @(negedge mclk);
      end
      chk(expCount, e);
      guardPowerDown = 1'b1;
      repeat (60) @(negedge mclk);
      chk(expCount, e);
      guardPowerDown = 1'b0;
      core.sfrWrite(GUARD_CTRL_ADDR, 8'h42);
      core.sfrWrite(GUARD_CTRL_ADDR, 8'h02);
      repeat (60) @(negedge mclk);
      chk({guardRunning, 8'(expCount - e)}, 9'h000);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      resetn = 1'b0;
      tickPowerDown = 1'b0;
      guardPowerDown = 1'b0;
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      t_reset();
      t_ticks();
      t_short();
      t_long();
      t_guard();
      wrap_up();
   end

   // Whole run needs roughly 5300 clocks; this leaves ample margin
   initial begin
      #200000;
      bad_count++;
      $display("ERROR %0t: run did not finish in time", $time);
      wrap_up();
   end
endmodule
